//--- shared/bfv_regs.svh
// timing counts, voltage codes and ramp constants for the converter control block
// assumes a 25 MHz core clock; included by bare name
`ifndef BFV_REGS_SVH
`define BFV_REGS_SVH
`define BFV_CLK_HZ 25000000
// overcurrent hold, in microseconds
`define BFV_OC_HOLD_US 500
`define BFV_OC_HOLD_CYC ((`BFV_OC_HOLD_US * (`BFV_CLK_HZ / 1000000)))
// reference held in millivolts
`define BFV_EXT_REF_MV 12'h258
// low range ramp step period in cycles (1 mV every 240 ns, about 4.2 V/ms)
`define BFV_LO_STEP_CYC 6
// external divider fixed ramp time, microseconds
`define BFV_EXT_RISE_US 225
`define BFV_EXT_STEP_CYC ((`BFV_EXT_RISE_US * (`BFV_CLK_HZ / 1000000)) / 600)
// thermal hysteresis default, degrees
`define BFV_THERM_HYST_C 25
`endif

//--- shared/bfv_pkg.sv
// types for the converter control block
// used with package-qualified names only
package bfv_pkg;
   typedef enum logic [4:0] {
      BFV_OFF = 5'h01,
      BFV_SOFT = 5'h02,
      BFV_REG = 5'h04,
      BFV_OCHOLD = 5'h08,
      BFV_THERM = 5'h10
   } bfv_state_e;
   typedef logic [11:0] bfv_mv_t;
endpackage : bfv_pkg

//--- src/bfv_buck_control.sv
// control state machine, voltage code decode and soft-start ramp of a buck converter
// comparator results and pins arrive synchronous to clk; switch gates go to drivers
// Operation
// - overcurrent trip turns high-side off and low-side on
// - hold low about 0.5 ms, then soft-start
// - persistent overcurrent repeats trip, hold, soft-start forever
// - over-temperature above 160 C stops all switching
// - restart with soft-start after temperature falls by hysteresis
// - switching disabled at power-up until input supply is sufficient
// - switching disabled again whenever input falls below lockout
// - enable low shuts down, enable high runs
// - selected code loads the reference DAC feeding the error amplifier
// - low range codes 000..110 map to 1.50 down to 0.80 V
// - low range code 111 selects external feedback against 0.6 V
// - code changes while running move reference glitch-free
// - high range codes 000..111 map to 3.30 down to 1.80 V
// - high range preset ramp is twice the low range rate
// - external divider mode uses a fixed ramp duration
`include "bfv_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module bfv_buck_control #(
   parameter int OC_HOLD_CYC = `BFV_OC_HOLD_CYC,
   parameter int LO_STEP_CYC = `BFV_LO_STEP_CYC,
   parameter int EXT_STEP_CYC = `BFV_EXT_STEP_CYC,
   parameter int THERM_HYST_C = `BFV_THERM_HYST_C
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic highRange,
   input wire logic enable,
   input wire logic supplyOk,
   input wire logic overcurrent,
   input wire logic overTemp,
   input wire logic volt_select_bit0,
   input wire logic volt_select_bit1,
   input wire logic volt_select_bit2,
   output logic highSideOn,
   output logic lowSideOn,
   output logic switchingEn,
   output logic [11:0] dacRefMv,
   output logic externalFeedbackSel,
   output logic rampDone,
   output logic [4:0] stateOut
);
   // elaboration check: hold counter is 16 bits, divider 8 bits, and the high range
   // halves the low step period, so that period must be even
   if (OC_HOLD_CYC < 1 || OC_HOLD_CYC > 65535 || LO_STEP_CYC < 2 || LO_STEP_CYC > 255 || (LO_STEP_CYC % 2) != 0
      || EXT_STEP_CYC < 1 || EXT_STEP_CYC > 255 || THERM_HYST_C < 1) begin : g_bad_param
      $error("bfv_buck_control: unsupported parameter value");
   end

   // code to target millivolts; used for both decode paths
   // every 3-bit code is listed in both tables, so no default is needed
   function automatic bfv_pkg::bfv_mv_t codeToMv(input logic hi, input logic [2:0] c);
      bfv_pkg::bfv_mv_t v;
      v = 12'h000;
      if (hi) begin
         unique case (c)
            3'h0: v = 12'hce4; // 3.30
            3'h1: v = 12'hbb8; // 3.00
            3'h2: v = 12'hb54; // 2.90
            3'h3: v = 12'ha28; // 2.60
            3'h4: v = 12'h9c4; // 2.50
            3'h5: v = 12'h898; // 2.20
            3'h6: v = 12'h834; // 2.10
            3'h7: v = 12'h708; // 1.80
         endcase
      end else begin
         unique case (c)
            3'h0: v = 12'h5dc; // 1.50
            3'h1: v = 12'h5aa; // 1.45
            3'h2: v = 12'h4b0; // 1.20
            3'h3: v = 12'h47e; // 1.15
            3'h4: v = 12'h44c; // 1.10
            3'h5: v = 12'h41a; // 1.05
            3'h6: v = 12'h320; // 0.80
            3'h7: v = `BFV_EXT_REF_MV; // external reference
         endcase
      end
      return v;
   endfunction : codeToMv

   // state, hold counter, step divider and reference ramp
   bfv_pkg::bfv_state_e state_reg, state_next;
   logic [15:0] holdCnt_reg;
   logic [7:0] stepCnt_reg;
   bfv_pkg::bfv_mv_t ramp_reg;

   // select decode
   // low range preset table
   // high range table, no external code
   wire logic [2:0] code = {volt_select_bit2, volt_select_bit1, volt_select_bit0};
   // low range 111 picks external divider
   wire logic extMode = !highRange && (code == 3'h7);
   wire bfv_pkg::bfv_mv_t target = codeToMv(highRange, code);
   // high range steps every half the low period
   // external mode: fixed duration, 600 steps total
   wire logic [7:0] stepPeriod = extMode ? 8'(EXT_STEP_CYC) :
      highRange ? 8'(LO_STEP_CYC / 2) : 8'(LO_STEP_CYC);
   wire logic stepTick = (stepCnt_reg == 8'h00);
   wire logic atTarget = (ramp_reg == target);
   wire logic runOk = enable && supplyOk;
   wire logic holdDone = (holdCnt_reg == 16'(OC_HOLD_CYC - 1));

   // hold count runs only in hold and clears on expiry, so every trip starts a full hold
   wire logic [15:0] holdCntNext = (state_reg == bfv_pkg::BFV_OCHOLD && !holdDone) ?
      holdCnt_reg + 16'h0001 : 16'h0000;
   // divider reload; a state change clears it so a ramp takes its first step on the next cycle
   wire logic [7:0] stepCntNext = stepTick ? stepPeriod - 8'h01 : stepCnt_reg - 8'h01;

   // stopped states keep the reference at zero, so each restart is a full soft-start
   wire logic rampStop = (state_reg == bfv_pkg::BFV_OFF) || (state_reg == bfv_pkg::BFV_OCHOLD)
      || (state_reg == bfv_pkg::BFV_THERM);
   // one millivolt toward the target in either direction; a code change slews, never jumps
   wire bfv_pkg::bfv_mv_t rampStepped = (ramp_reg < target) ? ramp_reg + 12'h001 : ramp_reg - 12'h001;

   // next state
   // enable and lockout take priority over everything
   always_comb begin
      state_next = state_reg;
      if (!runOk) begin
         state_next = bfv_pkg::BFV_OFF;
      end else begin
         unique case (state_reg)
            bfv_pkg::BFV_OFF: state_next = overTemp ? bfv_pkg::BFV_THERM : bfv_pkg::BFV_SOFT;
            bfv_pkg::BFV_SOFT, bfv_pkg::BFV_REG: begin
               // thermal stop ahead of current trip
               if (overTemp)
                  state_next = bfv_pkg::BFV_THERM;
               else if (overcurrent)
                  state_next = bfv_pkg::BFV_OCHOLD;
               else if (state_reg == bfv_pkg::BFV_SOFT && atTarget)
                  state_next = bfv_pkg::BFV_REG;
            end
            bfv_pkg::BFV_OCHOLD: begin
               if (overTemp)
                  state_next = bfv_pkg::BFV_THERM;
               else if (holdDone)
                  state_next = bfv_pkg::BFV_SOFT;
            end
            // overTemp is the comparator with hysteresis; clearing means cooled
            // limitation: the hysteresis amount is set in the sensor, not counted here
            bfv_pkg::BFV_THERM: if (!overTemp) state_next = bfv_pkg::BFV_SOFT;
            default: state_next = bfv_pkg::BFV_OFF;
         endcase
      end
   end

   // outputs decode the next state, so the ports change on the same edge as the state
   wire logic runningNext = (state_next == bfv_pkg::BFV_SOFT) || (state_next == bfv_pkg::BFV_REG);
   // low-side held on for the whole hold
   wire logic pullLowNext = (state_next == bfv_pkg::BFV_OCHOLD);
   wire logic regulateNext = (state_next == bfv_pkg::BFV_REG);

   // state and hold counter
   // hold measured on the clock
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= bfv_pkg::BFV_OFF;
         holdCnt_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         holdCnt_reg <= holdCntNext;
      end
   end

   // ramp divider: one step enable per stepPeriod cycles
   always_ff @(posedge clk) begin
      if (sys_rst || state_reg != state_next)
         stepCnt_reg <= 8'h00;
      else
         stepCnt_reg <= stepCntNext;
   end

   // reference ramp; one millivolt per step so code changes never jump
   // running code changes slew, no glitch
   // restart from zero toward current target
   always_ff @(posedge clk) begin
      if (sys_rst || rampStop)
         ramp_reg <= 12'h000;
      else if (stepTick && !atTarget)
         ramp_reg <= rampStepped;
   end

   // switch gates; pwm permission is switchingEn, so the forced high-side request stays low
   // low-side on during hold; all off in thermal
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         highSideOn <= 1'b0;
         lowSideOn <= 1'b0;
         switchingEn <= 1'b0;
      end else begin
         highSideOn <= 1'b0;
         lowSideOn <= pullLowNext;
         switchingEn <= runningNext;
      end
   end

   // reference and status
   // ramped reference drives the DAC
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dacRefMv <= 12'h000;
         externalFeedbackSel <= 1'b0;
         rampDone <= 1'b0;
         stateOut <= 5'h01;
      end else begin
         dacRefMv <= ramp_reg;
         externalFeedbackSel <= extMode;
         rampDone <= regulateNext;
         stateOut <= state_next;
      end
   end
endmodule : bfv_buck_control
`default_nettype wire

//--- tb/bfv_control_properties.sv
// properties of the converter control ports
// bound to the control block from tb_top
`timescale 1ns/1ps
`default_nettype none
module bfv_control_checker #(
   parameter int OC_HOLD_CYC = 20
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic enable,
   input wire logic supplyOk,
   input wire logic overcurrent,
   input wire logic overTemp,
   input wire logic highSideOn,
   input wire logic lowSideOn,
   input wire logic switchingEn,
   input wire logic [11:0] dacRefMv,
   input wire logic [4:0] stateOut
);
   logic [15:0] holdCnt;
   wire run = enable && supplyOk;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // cycles pulled low, so the hold length is seen from both ends
   always_ff @(posedge clk) holdCnt <= lowSideOn ? holdCnt + 16'h1 : 16'h0;
   chk_oc_trip: assert property (run && !overTemp && overcurrent && switchingEn |=> lowSideOn && !highSideOn)
      else $error("no trip");
   chk_hold_max: assert property (lowSideOn |-> holdCnt <= 16'(OC_HOLD_CYC + 1))
      else $error("hold long");
   chk_hold_min: assert property ($fell(lowSideOn) && $past(run && !overTemp) |-> $past(holdCnt) >= 16'(OC_HOLD_CYC - 3))
      else $error("hold short");
   chk_therm_stop: assert property (run && overTemp |=> stateOut == 5'h10 && !switchingEn)
      else $error("no thermal stop");
   chk_therm_back: assert property (stateOut == 5'h10 && run && !overTemp |=> stateOut == 5'h02)
      else $error("no restart");
   chk_lockout: assert property (!supplyOk |=> stateOut == 5'h01 && !switchingEn && !lowSideOn)
      else $error("lockout ignored");
   chk_enable_off: assert property (!enable |=> stateOut == 5'h01 && !switchingEn)
      else $error("enable ignored");
   chk_ref_slew: assert property ($changed(dacRefMv) |-> dacRefMv == 12'h0
      || dacRefMv == $past(dacRefMv) + 12'h1 || dacRefMv + 12'h1 == $past(dacRefMv)) else $error("ref jump");
   cover property (lowSideOn ##[1:40] switchingEn);
   cover property (stateOut == 5'h10);
   cover property (dacRefMv == 12'h258);
   cover property ($fell(lowSideOn) ##[1:3] $rose(lowSideOn));
endmodule : bfv_control_checker
`default_nettype wire

//--- tb/bfv_host_model.sv
// host model driving enable and the three select pins
// registers requests on the clock; pins are never left floating
`timescale 1ns/1ps
`default_nettype none
module bfv_host_model (
   input wire logic clk,
   input wire logic highRange,
   input wire logic runReq,
   input wire logic [2:0] codeReq,
   output logic enable,
   output logic [2:0] code
);
   wire crossExt = !highRange && ((code == 3'h7) != (codeReq == 3'h7));
   initial begin
      enable = 1'b0;
      code = 3'h0;
   end
   // a preset to external move drops enable first, the code changes only while stopped
   always @(posedge clk) begin
      enable <= runReq && !(crossExt && enable);
      code <= (crossExt && enable) ? code : codeReq;
   end
endmodule : bfv_host_model
`default_nettype wire

//--- tb/tb_top.sv
// bench for the converter control block and its host model
// 25 MHz clock; overcurrent hold shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, sys_rst = 1'b1, highRange = 1'b0, runReq = 1'b0;
   logic supplyOk = 1'b0, overcurrent = 1'b0, overTemp = 1'b0;
   logic [2:0] codeReq = 3'h6;
   wire enable, highSideOn, lowSideOn, switchingEn, externalFeedbackSel, rampDone;
   wire [2:0] code;
   wire [11:0] dacRefMv;
   wire [4:0] stateOut;
   int fails = 0, tests_run = 0, cyc = 0, n;
   logic [11:0] lo [8] = '{12'h5dc, 12'h5aa, 12'h4b0, 12'h47e, 12'h44c, 12'h41a, 12'h320, 12'h258};
   logic [11:0] hi [8] = '{12'hce4, 12'hbb8, 12'hb54, 12'ha28, 12'h9c4, 12'h898, 12'h834, 12'h708};
   always #20 clk = ~clk;
   bfv_host_model i_bfv_host_model (.clk(clk), .highRange(highRange), .runReq(runReq), .codeReq(codeReq),
      .enable(enable), .code(code));
   bfv_buck_control #(.OC_HOLD_CYC(20)) i_bfv_buck_control (.clk(clk), .sys_rst(sys_rst), .highRange(highRange),
      .enable(enable), .supplyOk(supplyOk), .overcurrent(overcurrent), .overTemp(overTemp),
      .volt_select_bit0(code[0]), .volt_select_bit1(code[1]), .volt_select_bit2(code[2]),
      .highSideOn(highSideOn), .lowSideOn(lowSideOn), .switchingEn(switchingEn), .dacRefMv(dacRefMv),
      .externalFeedbackSel(externalFeedbackSel), .rampDone(rampDone), .stateOut(stateOut));
   task check(input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick
   // bounded waits on the reference and on the state
   task waitRef(input logic [11:0] exp);
      for (n = 0; n < 12000 && dacRefMv !== exp; n++) tick(1);
      check(dacRefMv, exp);
   endtask : waitRef
   task waitSt(input logic [4:0] s);
      for (n = 0; n < 200 && stateOut !== s; n++) tick(1);
      check(stateOut, s);
   endtask : waitSt
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   always @(posedge clk) begin
      cyc++;
      if (cyc > 90000) begin
         fails++;
         report_and_stop();
      end
   end
   initial begin
      tick(12);
      sys_rst <= 1'b0;
      runReq <= 1'b1;
      tick(6);
      check(switchingEn, 1'b0);
      supplyOk <= 1'b1;
      waitRef(lo[6]);
      check(12'((n + 8) / 800), 12'h6);
      for (int c = 5; c >= 0; c--) begin
         codeReq <= 3'(c);
         waitRef(lo[c]);
      end
      tick(3);
      check(rampDone, 1'b1);
      codeReq <= 3'h7;
      waitRef(12'h258);
      check(12'((n + 8) / 600), 12'h9);
      check(externalFeedbackSel, 1'b1);
      $display("presets and external mode done");
      overcurrent <= 1'b1;
      tick(2);
      check({lowSideOn, highSideOn, switchingEn}, 3'h4);
      waitSt(5'h02);
      check(12'((n + 4) / 20), 12'h1);
      waitSt(5'h08);
      overcurrent <= 1'b0;
      waitSt(5'h02);
      overTemp <= 1'b1;
      tick(2);
      check({stateOut, switchingEn}, 6'h20);
      overTemp <= 1'b0;
      waitSt(5'h02);
      supplyOk <= 1'b0;
      tick(2);
      check(stateOut, 5'h01);
      supplyOk <= 1'b1;
      runReq <= 1'b0;
      tick(3);
      check(stateOut, 5'h01);
      $display("protection done");
      highRange <= 1'b1;
      codeReq <= 3'h0;
      runReq <= 1'b1;
      waitRef(hi[0]);
      check(12'((n + 8) / 3300), 12'h3);
      for (int c = 1; c < 8; c++) begin
         codeReq <= 3'(c);
         waitRef(hi[c]);
      end
      check(externalFeedbackSel, 1'b0);
      $display("high range done");
      report_and_stop();
   end
endmodule : tb_top
bind bfv_buck_control bfv_control_checker #(.OC_HOLD_CYC(OC_HOLD_CYC)) i_bfv_control_checker (.clk(clk),
   .sys_rst(sys_rst), .enable(enable), .supplyOk(supplyOk), .overcurrent(overcurrent), .overTemp(overTemp),
   .highSideOn(highSideOn), .lowSideOn(lowSideOn), .switchingEn(switchingEn), .dacRefMv(dacRefMv),
   .stateOut(stateOut));
`default_nettype wire
